/* bench/pks_link_chk.sv */
// checker on the host/module link
`timescale 1ns/1ps
module pks_link_chk #(
  parameter int unsigned ON_CYC = pks_pkg::ON_HOLD_CYC,
  parameter int unsigned OFF_CYC = pks_pkg::OFF_HOLD_CYC,
  parameter int unsigned RST_CYC = pks_pkg::RST_HOLD_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // link
  input wire logic key_n,
  input wire logic rst_od_oe,
  input wire logic rst_line_n,
  input wire logic power_state_out
);
  logic [31:0] key_cnt_r, key_cnt_nxt, rst_cnt_r, rst_cnt_nxt;
  // ============================================================
  // hold counters
  always_comb begin
    key_cnt_nxt = key_n ? 32'h0 : key_cnt_r + 32'h1;
    rst_cnt_nxt = rst_od_oe ? rst_cnt_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge core_clk) begin
    key_cnt_r <= sys_rst ? 32'h0 : key_cnt_nxt;
    rst_cnt_r <= sys_rst ? 32'h0 : rst_cnt_nxt;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ============================================================
  // link rules
  a_key_hold_on: assert property ($rose(key_n) |-> key_cnt_r >= ON_CYC)
    else $error("key hold short");
  a_key_hold_off: assert property (
    $rose(key_n) && power_state_out |-> key_cnt_r >= OFF_CYC)
    else $error("off hold short");
  a_power_rise: assert property (
    $rose(key_n) && !power_state_out |-> ##[1:8] power_state_out)
    else $error("no power up");
  a_hold_keeps_on: assert property (!key_n && power_state_out |=> power_state_out)
    else $error("off while key held");
  a_off_after_rel: assert property ($fell(power_state_out) |-> key_n && $past(key_n, 8))
    else $error("off too early");
  a_pull_up: assert property (!rst_od_oe |-> rst_line_n)
    else $error("restart line low");
  a_open_drain: assert property (rst_od_oe |-> !rst_line_n)
    else $error("restart not pulled");
  a_rst_hold: assert property ($fell(rst_od_oe) |-> rst_cnt_r >= RST_CYC)
    else $error("restart hold short");
  a_restart_up: assert property ($fell(rst_od_oe) |-> ##[1:8] power_state_out)
    else $error("no restart boot");
  a_one_cmd: assert property (rst_od_oe |-> key_n)
    else $error("two commands");
endmodule

/* bench/power_key_restart_sequencer_test.sv */
// top test of the power key / restart sequencer
`timescale 1ns/1ps
module power_key_restart_sequencer_test;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  localparam int unsigned T_ON = 20;
  localparam int unsigned T_OFF = 40;
  localparam int unsigned T_RST = 10;
  logic cmd_toggle = 1'b0, cmd_restart = 1'b0, sw_off_req = 1'b0, detach_done = 1'b0;
  logic sw_off_b = 1'b0, detach_done_b = 1'b0, det_b;
  logic busy, module_on, detach_req, restart_evt, powered_on, evt_b;
  int miscompares = 0, cmp_count = 0, det_cnt = 0, evt_cnt = 0, evt_b_cnt = 0;
  always #50 core_clk = ~core_clk;
  pks_link_if link ();
  pks_link_if link_b ();
  pks_host #(.ON_CYC(T_ON), .OFF_CYC(T_OFF), .RST_CYC(T_RST)) pks_host_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(link), .cmd_toggle(cmd_toggle),
    .cmd_restart(cmd_restart), .busy(busy), .module_on(module_on));
  pks_device #(.ON_CYC(T_ON), .OFF_CYC(T_OFF), .RST_CYC(T_RST)) pks_device_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(link), .sw_off_req(sw_off_req),
    .detach_done(detach_done), .detach_req(detach_req), .restart_evt(restart_evt),
    .powered_on(powered_on));
  // second module end, driven straight from the test through hold_b with short and long holds
  pks_device #(.ON_CYC(T_ON), .OFF_CYC(T_OFF), .RST_CYC(T_RST)) pks_device_inst_b (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(link_b), .sw_off_req(sw_off_b),
    .detach_done(detach_done_b), .detach_req(det_b), .restart_evt(evt_b), .powered_on());
  pks_link_chk #(.ON_CYC(T_ON), .OFF_CYC(T_OFF), .RST_CYC(T_RST)) pks_link_chk_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .key_n(link.key_n), .rst_od_oe(link.rst_od_oe),
    .rst_line_n(link.rst_line_n), .power_state_out(link.power_state_out));
  // network answers a detach one cycle later
  always @(posedge core_clk) begin
    detach_done <= detach_req;
    detach_done_b <= det_b;
    det_cnt <= det_cnt + int'(detach_req);
    evt_cnt <= evt_cnt + int'(restart_evt);
    evt_b_cnt <= evt_b_cnt + int'(evt_b);
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic tg, input logic rs);
    int n;
    n = 0;
    @(posedge core_clk);
    cmd_toggle <= tg;
    cmd_restart <= rs;
    @(posedge core_clk);
    cmd_toggle <= 1'b0;
    cmd_restart <= 1'b0;
    do @(negedge core_clk); while (busy !== 1'b0 && ++n < 400);
    chk("busy", 1'b0, busy);
    repeat (20) @(negedge core_clk);
  endtask
  task automatic hold_b(input int n, input logic rs);
    @(posedge core_clk);
    if (rs) link_b.rst_od_oe <= 1'b1;
    else link_b.key_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    link_b.rst_od_oe <= 1'b0;
    link_b.key_n <= 1'b1;
    repeat (30) @(negedge core_clk);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge core_clk);
    miscompares++;
    complete_run();
  end
  initial begin
    int d0;
    link_b.key_n <= 1'b1;
    link_b.rst_od_oe <= 1'b0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    chk("power", 1'b0, link.power_state_out);
    cmd(1'b1, 1'b0);
    chk("on", 1'b1, powered_on);
    chk("monitor", 1'b1, module_on);
    $display("test 1 done");
    @(posedge core_clk);
    sw_off_req <= 1'b1;
    @(posedge core_clk);
    sw_off_req <= 1'b0;
    repeat (60) @(negedge core_clk);
    chk("sw detach", 1'b1, det_cnt > 0);
    chk("sw off", 1'b0, link.power_state_out);
    $display("test 2 done");
    cmd(1'b1, 1'b0);
    d0 = det_cnt;
    cmd(1'b1, 1'b0);
    chk("key detach", 1'b1, det_cnt != d0);
    chk("key off", 1'b0, link.power_state_out);
    $display("test 3 done");
    cmd(1'b0, 1'b1);
    chk("restart pulse", 1, evt_cnt);
    chk("restart on", 1'b1, link.power_state_out);
    $display("test 4 done");
    hold_b(10, 1'b0);
    chk("short key", 1'b0, link_b.power_state_out);
    hold_b(24, 1'b0);
    chk("long key", 1'b1, link_b.power_state_out);
    hold_b(30, 1'b0);
    chk("mid key", 1'b1, link_b.power_state_out);
    hold_b(5, 1'b1);
    chk("short restart", 0, evt_b_cnt);
    chk("pull up", 1'b1, link_b.rst_line_n);
    hold_b(14, 1'b1);
    chk("long restart", 1, evt_b_cnt);
    @(posedge core_clk);
    sw_off_b <= 1'b1;
    @(posedge core_clk);
    sw_off_b <= 1'b0;
    repeat (60) @(negedge core_clk);
    chk("b sw off", 1'b0, link_b.power_state_out);
    $display("test 5 done");
    complete_run();
  end
endmodule

/* verilog/pks_device.sv */
// module end: decodes key and restart holds, sequences power
// ============================================================
`timescale 1ns/1ps
module pks_device #(
  parameter int unsigned ON_CYC = pks_pkg::ON_HOLD_CYC,
  parameter int unsigned OFF_CYC = pks_pkg::OFF_HOLD_CYC,
  parameter int unsigned RST_CYC = pks_pkg::RST_HOLD_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // link
  pks_link_if.dev link,
  // user side
  input wire logic sw_off_req,
  input wire logic detach_done,
  output logic detach_req,
  output logic restart_evt,
  output logic powered_on
);
  // ============================================================
  // input synchronisers
  // only the second stage is read; the edge detectors keep a copy of it
  // one cycle late, reset to the released level so that leaving reset
  // never looks like the end of a hold
  logic [1:0] key_s_r, key_s_nxt;
  logic [1:0] rst_s_r, rst_s_nxt;
  logic key_was_low_r, key_was_low_nxt;
  logic rst_was_low_r, rst_was_low_nxt;
  logic key_low;
  logic rst_low;
  assign key_low = ~key_s_r[1];
  assign rst_low = ~rst_s_r[1];
  always_comb begin
    key_s_nxt = {key_s_r[0], link.key_n};
    rst_s_nxt = {rst_s_r[0], link.rst_line_n};
    key_was_low_nxt = key_low;
    rst_was_low_nxt = rst_low;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      key_s_r <= 2'h3;
      rst_s_r <= 2'h3;
      key_was_low_r <= 1'h0;
      rst_was_low_r <= 1'h0;
    end else begin
      key_s_r <= key_s_nxt;
      rst_s_r <= rst_s_nxt;
      key_was_low_r <= key_was_low_nxt;
      rst_was_low_r <= rst_was_low_nxt;
    end
  end

  // ============================================================
  // hold counters
  logic [pks_pkg::CNT_W-1:0] key_cnt_r, key_cnt_nxt;
  logic [pks_pkg::CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;
  always_comb begin
    key_cnt_nxt = key_cnt_r;
    rst_cnt_nxt = rst_cnt_r;
    if (!key_low) begin
      key_cnt_nxt = '0;
    end else if (key_cnt_r < pks_pkg::CNT_W'(OFF_CYC)) begin
      key_cnt_nxt = key_cnt_r + 1'b1;
    end
    if (!rst_low) begin
      rst_cnt_nxt = '0;
    end else if (rst_cnt_r < pks_pkg::CNT_W'(RST_CYC)) begin
      rst_cnt_nxt = rst_cnt_r + 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      key_cnt_r <= '0;
      rst_cnt_r <= '0;
    end else begin
      key_cnt_r <= key_cnt_nxt;
      rst_cnt_r <= rst_cnt_nxt;
    end
  end
  // counts saturate, so a long hold never wraps into a short one;
  // any hold past the saturation point reads as the longest hold

  // ============================================================
  // release edges
  // a qualified hold acts in the first cycle the line reads high again;
  // the counter still holds the length of the hold in that cycle
  function automatic logic hold_released(input logic was_low, input logic now_low,
      input logic [pks_pkg::CNT_W-1:0] cnt, input logic [pks_pkg::CNT_W-1:0] need);
    return was_low && !now_low && (cnt >= need);
  endfunction
  logic key_rel_on, key_rel_off, rst_rel;
  assign key_rel_on = hold_released(key_was_low_r, key_low, key_cnt_r,
      pks_pkg::CNT_W'(ON_CYC));
  assign key_rel_off = hold_released(key_was_low_r, key_low, key_cnt_r,
      pks_pkg::CNT_W'(OFF_CYC));
  assign rst_rel = hold_released(rst_was_low_r, rst_low, rst_cnt_r,
      pks_pkg::CNT_W'(RST_CYC));

  // ============================================================
  // power sequencer
  pks_pkg::pks_dev_state_t st_r, st_nxt;
  logic [pks_pkg::CNT_W-1:0] tmr_r, tmr_nxt;
  logic restart_nxt;
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    restart_nxt = 1'b0;
    if (rst_rel) begin
      // unconditional restart wins over any sequence in progress
      restart_nxt = 1'b1;
      st_nxt = pks_pkg::PKS_BOOT;
      tmr_nxt = '0;
    end else begin
      unique case (st_r)
        pks_pkg::PKS_OFF: begin
          if (key_rel_on) begin
            st_nxt = pks_pkg::PKS_BOOT;
            tmr_nxt = '0;
          end
        end
        pks_pkg::PKS_BOOT: begin
          if (tmr_r >= pks_pkg::CNT_W'(pks_pkg::BOOT_CYC)) begin
            st_nxt = pks_pkg::PKS_ON;
          end else begin
            tmr_nxt = tmr_r + 1'b1;
          end
        end
        pks_pkg::PKS_ON: begin
          // shutdown on release of key after the off hold, or on sw_off_req
          if (key_rel_off || sw_off_req) begin
            st_nxt = pks_pkg::PKS_DETACH;
          end
        end
        pks_pkg::PKS_DETACH: begin
          if (detach_done) begin
            st_nxt = pks_pkg::PKS_DOWN;
            tmr_nxt = '0;
          end
        end
        pks_pkg::PKS_DOWN: begin
          if (tmr_r >= pks_pkg::CNT_W'(pks_pkg::DOWN_CYC)) begin
            st_nxt = pks_pkg::PKS_OFF;
          end else begin
            tmr_nxt = tmr_r + 1'b1;
          end
        end
        default: begin
          st_nxt = pks_pkg::PKS_OFF;
        end
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= pks_pkg::PKS_OFF;
      tmr_r <= '0;
      restart_evt <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      restart_evt <= restart_nxt;
    end
  end

  // ============================================================
  // outputs
  // levels leave flops fed from the next state, so they switch in the
  // same cycle as the state and carry no decode glitches onto the pins
  logic detach_req_r, detach_req_nxt;
  logic powered_on_r, powered_on_nxt;
  logic power_out_r, power_out_nxt;
  always_comb begin
    detach_req_nxt = st_nxt == pks_pkg::PKS_DETACH;
    powered_on_nxt = st_nxt == pks_pkg::PKS_ON;
    // monitor low only when fully off
    power_out_nxt = st_nxt != pks_pkg::PKS_OFF;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      detach_req_r <= 1'h0;
      powered_on_r <= 1'h0;
      power_out_r <= 1'h0;
    end else begin
      detach_req_r <= detach_req_nxt;
      powered_on_r <= powered_on_nxt;
      power_out_r <= power_out_nxt;
    end
  end
  assign detach_req = detach_req_r;
  assign powered_on = powered_on_r;
  assign link.power_state_out = power_out_r;
endmodule

/* verilog/pks_host.sv */
// host end: times key and restart holds, waits on power monitor after a key hold only
`timescale 1ns/1ps
module pks_host #(
  parameter int unsigned ON_CYC = pks_pkg::ON_HOLD_CYC,
  parameter int unsigned OFF_CYC = pks_pkg::OFF_HOLD_CYC,
  parameter int unsigned RST_CYC = pks_pkg::RST_HOLD_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // link
  pks_link_if.host link,
  // user side
  input wire logic cmd_toggle,
  input wire logic cmd_restart,
  output logic busy,
  output logic module_on
);
  // ============================================================
  // monitor synchroniser
  logic [1:0] mon_s_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mon_s_r <= 2'h0;
    end else begin
      mon_s_r <= {mon_s_r[0], link.power_state_out};
    end
  end
  assign module_on = mon_s_r[1];

  // ============================================================
  // hold sequencer
  pks_pkg::pks_host_state_t st_r, st_nxt;
  logic [pks_pkg::CNT_W-1:0] cnt_r, cnt_nxt, len_r, len_nxt;
  logic is_rst_r, is_rst_nxt, mon_start_r, mon_start_nxt;
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    is_rst_nxt = is_rst_r;
    mon_start_nxt = mon_start_r;
    unique case (st_r)
      pks_pkg::PKS_H_IDLE: begin
        cnt_nxt = '0;
        mon_start_nxt = mon_s_r[1];
        if (cmd_restart) begin
          // restart used only on explicit request
          st_nxt = pks_pkg::PKS_H_HOLD;
          is_rst_nxt = 1'b1;
          len_nxt = pks_pkg::CNT_W'(RST_CYC);
        end else if (cmd_toggle) begin
          st_nxt = pks_pkg::PKS_H_HOLD;
          is_rst_nxt = 1'b0;
          // on needs 1 s, off needs 2 s
          len_nxt = mon_s_r[1] ? pks_pkg::CNT_W'(OFF_CYC) : pks_pkg::CNT_W'(ON_CYC);
        end
      end
      pks_pkg::PKS_H_HOLD: begin
        if (cnt_r >= len_r + 2'd3) begin
          st_nxt = pks_pkg::PKS_H_WAIT;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      pks_pkg::PKS_H_WAIT: begin
        if (is_rst_r || mon_s_r[1] != mon_start_r) begin
          st_nxt = pks_pkg::PKS_H_IDLE;
        end
      end
      default: begin
        st_nxt = pks_pkg::PKS_H_IDLE;
      end
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= pks_pkg::PKS_H_IDLE;
      cnt_r <= '0;
      len_r <= '0;
      is_rst_r <= 1'b0;
      mon_start_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      is_rst_r <= is_rst_nxt;
      mon_start_r <= mon_start_nxt;
    end
  end
  assign busy = st_r != pks_pkg::PKS_H_IDLE;
  assign link.key_n = !(st_r == pks_pkg::PKS_H_HOLD && !is_rst_r);
  assign link.rst_od_oe = st_r == pks_pkg::PKS_H_HOLD && is_rst_r;
endmodule

/* verilog/pks_link_if.sv */
// link between host and module: key line, restart line, power monitor
`timescale 1ns/1ps
interface pks_link_if;
  logic key_n;
  logic rst_od_oe;
  logic power_state_out;
  // open-collector restart line with the module's internal pull-up
  logic rst_line_n;
  assign rst_line_n = rst_od_oe ? 1'b0 : 1'b1;
  modport dev (
    input key_n,
    input rst_line_n,
    output power_state_out
  );
  modport host (
    output key_n,
    output rst_od_oe,
    input power_state_out
  );
endinterface

/* verilog/pks_pkg.sv */
// shared constants and types for the power key / restart sequencer
package pks_pkg;
  // ============================================================
  // timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned ON_HOLD_MS = 1000;
  localparam int unsigned OFF_HOLD_MS = 2000;
  localparam int unsigned RST_HOLD_MS = 200;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned ON_HOLD_CYC = ON_HOLD_MS * CYC_PER_MS;
  localparam int unsigned OFF_HOLD_CYC = OFF_HOLD_MS * CYC_PER_MS;
  localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * CYC_PER_MS;
  localparam int unsigned BOOT_CYC = 16;
  localparam int unsigned DOWN_CYC = 16;
  localparam int CNT_W = 32;
  // ============================================================
  // states of the module end (gray from PKS_OFF to PKS_DOWN; PKS_DOWN back to PKS_OFF flips two bits)
  typedef enum logic [2:0] {
    PKS_OFF = 3'h0,
    PKS_BOOT = 3'h1,
    PKS_ON = 3'h3,
    PKS_DETACH = 3'h2,
    PKS_DOWN = 3'h6
  } pks_dev_state_t;
  // states of the host end
  typedef enum logic [1:0] {
    PKS_H_IDLE = 2'h0,
    PKS_H_HOLD = 2'h1,
    PKS_H_WAIT = 2'h3
  } pks_host_state_t;
endpackage
